// ### rtl/wss_pkg.sv
// constants for the waveform steering and shutdown block
package wss_pkg;
  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 32;
  localparam int          NOUT       = 4;
  localparam int          DB_W       = 6;
  localparam int          NSRC       = 4;
  // ************************************
  // register byte offsets
  // ************************************
  localparam logic [7:0]  OFF_MAIN   = 8'h00;
  localparam logic [7:0]  OFF_POL    = 8'h04;
  localparam logic [7:0]  OFF_DBR    = 8'h08;
  localparam logic [7:0]  OFF_DBF    = 8'h0c;
  localparam logic [7:0]  OFF_SD     = 8'h10;
  localparam logic [7:0]  OFF_SRC    = 8'h14;
  localparam logic [7:0]  OFF_STR    = 8'h18;
  localparam logic [7:0]  OFF_CLK    = 8'h1c;
  // ************************************
  // field positions
  // ************************************
  localparam int          EN_BIT     = 7;
  localparam int          LOAD_BIT   = 6;
  localparam int          MODE_LSB   = 0;
  localparam int          IN_BIT     = 5;
  localparam int          SD_BIT     = 7;
  localparam int          REN_BIT    = 6;
  localparam int          OVR_BD_LSB = 4;
  localparam int          OVR_AC_LSB = 2;
  localparam int          FIX_LSB    = 4;
  localparam int          CS_BIT     = 0;
  // ************************************
  // codes and reset values
  // ************************************
  localparam logic [2:0]  MODE_ASYNC = 3'h0;
  localparam logic [2:0]  MODE_SYNC  = 3'h1;
  localparam logic [2:0]  MODE_FWD   = 3'h2;
  localparam logic [2:0]  MODE_REV   = 3'h3;
  localparam logic [2:0]  MODE_HALF  = 3'h4;
  localparam logic [2:0]  MODE_PP    = 3'h5;
  localparam logic [1:0]  OVR_ONE    = 2'h3;
  localparam logic [1:0]  OVR_ZERO   = 2'h2;
  localparam logic [1:0]  OVR_HIZ    = 2'h1;
  localparam logic [1:0]  OVR_INACT  = 2'h0;
  localparam logic [1:0]  OVR_RST    = 2'h1;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;
endpackage

// ### rtl/wss_waveform_steering_shutdown.sv
// steering, shutdown and control logic of the four-output waveform generator
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module wss_waveform_steering_shutdown (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        wave_in,
  input  wire logic        comparator_one_sync_out,
  input  wire logic        comparator_two_sync_out,
  input  wire logic        timer_postscaled_out,
  input  wire logic        shutdown_input_pin,
  output logic [3:0]       out_o,
  output logic [3:0]       out_oe,
  output logic             osc_keep_on
);
  // ****************************************
  // state
  // ****************************************
  logic [7:0]  aw_q;
  logic [31:0] w_q;
  logic [3:0]  ws_q;
  logic        aw_full;
  logic        w_full;
  logic        en_reg;
  logic        load_req_reg;
  logic [2:0]  mode_reg;
  logic [3:0]  pol_reg;
  logic [5:0]  dbr_reg;
  logic [5:0]  dbf_reg;
  logic [5:0]  dbr_act;
  logic [5:0]  dbf_act;
  logic        sd_reg;
  logic        ren_reg;
  logic [1:0]  ovr_bd_reg;
  logic [1:0]  ovr_ac_reg;
  logic [3:0]  src_en_reg;
  logic [3:0]  str_reg;
  logic [3:0]  fix_reg;
  logic [3:0]  str_sync;
  logic        cs_reg;
  logic        hold_reg;
  logic [5:0]  db_cnt;
  logic        in_m, in_s, in_d;
  logic [3:0]  src_m, src_s;
  localparam int DB_HI = wss_pkg::DB_W - 1;
  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, wss_pkg::OFF_MAIN) | hit(a, wss_pkg::OFF_POL) |
             hit(a, wss_pkg::OFF_DBR) | hit(a, wss_pkg::OFF_DBF) |
             hit(a, wss_pkg::OFF_SD) | hit(a, wss_pkg::OFF_SRC) |
             hit(a, wss_pkg::OFF_STR) | hit(a, wss_pkg::OFF_CLK);
  endfunction

  logic wr_go, wr_ok;
  logic wr_main, wr_pol, wr_dbr, wr_dbf, wr_sd, wr_src, wr_str, wr_clk;
  logic [7:0] wd;
  assign wr_go = aw_full & w_full & ~s_axi_bvalid;
  assign wr_ok = wr_go & ws_q[0] & mapped(aw_q);
  assign wd    = w_q[7:0];

  always_comb begin
    wr_main = 1'b0;
    wr_pol  = 1'b0;
    wr_dbr  = 1'b0;
    wr_dbf  = 1'b0;
    wr_sd   = 1'b0;
    wr_src  = 1'b0;
    wr_str  = 1'b0;
    wr_clk  = 1'b0;
    if (!wr_ok) begin
    end else if (hit(aw_q, wss_pkg::OFF_MAIN)) begin
      wr_main = 1'b1;
    end else if (hit(aw_q, wss_pkg::OFF_POL)) begin
      wr_pol = 1'b1;
    end else if (hit(aw_q, wss_pkg::OFF_DBR)) begin
      wr_dbr = 1'b1;
    end else if (hit(aw_q, wss_pkg::OFF_DBF)) begin
      wr_dbf = 1'b1;
    end else if (hit(aw_q, wss_pkg::OFF_SD)) begin
      wr_sd = 1'b1;
    end else if (hit(aw_q, wss_pkg::OFF_SRC)) begin
      wr_src = 1'b1;
    end else if (hit(aw_q, wss_pkg::OFF_STR)) begin
      wr_str = 1'b1;
    end else begin
      wr_clk = 1'b1;
    end
  end
  // ****************************************
  // axi4-lite write channel
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_q          <= 8'h00;
      w_q           <= 32'h0000_0000;
      ws_q          <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= wss_pkg::RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= ~s_axi_awready & s_axi_awvalid & ~aw_full & ~s_axi_bvalid;
      s_axi_wready  <= ~s_axi_wready & s_axi_wvalid & ~w_full & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_q    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_q    <= s_axi_wdata;
        ws_q   <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_q) ? wss_pkg::RESP_OKAY : wss_pkg::RESP_SLV;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // ****************************************
  // axi4-lite read channel
  // ****************************************
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (hit(s_axi_araddr, wss_pkg::OFF_MAIN)) begin
      rd_mux = {en_reg, load_req_reg, 3'h0, mode_reg};
    end else if (hit(s_axi_araddr, wss_pkg::OFF_POL)) begin
      rd_mux = {2'h0, in_s, 1'b0, pol_reg};
    end else if (hit(s_axi_araddr, wss_pkg::OFF_DBR)) begin
      rd_mux = {2'h0, dbr_reg};
    end else if (hit(s_axi_araddr, wss_pkg::OFF_DBF)) begin
      rd_mux = {2'h0, dbf_reg};
    end else if (hit(s_axi_araddr, wss_pkg::OFF_SD)) begin
      rd_mux = {sd_reg, ren_reg, ovr_bd_reg, ovr_ac_reg, 2'h0};
    end else if (hit(s_axi_araddr, wss_pkg::OFF_SRC)) begin
      rd_mux = {4'h0, src_en_reg};
    end else if (hit(s_axi_araddr, wss_pkg::OFF_STR)) begin
      rd_mux = {fix_reg, str_reg};
    end else if (hit(s_axi_araddr, wss_pkg::OFF_CLK)) begin
      rd_mux = {7'h00, cs_reg};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= wss_pkg::RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= ~s_axi_arready & s_axi_arvalid & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_mux};
        s_axi_rresp  <= mapped(s_axi_araddr) ? wss_pkg::RESP_OKAY : wss_pkg::RESP_SLV;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ****************************************
  // pin synchronisers and input events
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_m  <= 1'b0;
      in_s  <= 1'b0;
      in_d  <= 1'b0;
      src_m <= 4'hf;
      src_s <= 4'hf;
    end else if (clk_en) begin
      in_m  <= wave_in;
      in_s  <= in_m;
      in_d  <= in_s;
      src_m <= {comparator_two_sync_out, comparator_one_sync_out,
                timer_postscaled_out, shutdown_input_pin};
      src_s <= src_m;
    end
  end

  logic rise_ev, fall_ev, src_act, steer, async_m;
  logic [3:0] str_use;
  assign rise_ev = in_s & ~in_d;
  assign fall_ev = ~in_s & in_d;
  // sources are active low; only enabled ones count
  assign src_act = |(src_en_reg & ~src_s);
  assign async_m = (mode_reg == wss_pkg::MODE_ASYNC);
  assign steer   = async_m | (mode_reg == wss_pkg::MODE_SYNC);
  // async mode bypasses the edge-aligned copy so a write lands at once
  // sync mode takes the new selection in the rising-edge cycle itself, so no pulse is clipped
  assign str_use = (async_m || rise_ev) ? str_reg : str_sync;
  // ****************************************
  // main control and dead-band buffers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_reg       <= 1'b0;
      load_req_reg <= 1'b0;
      mode_reg     <= wss_pkg::MODE_ASYNC;
    end else if (clk_en) begin
      if (wr_main) begin
        en_reg       <= wd[wss_pkg::EN_BIT];
        mode_reg     <= wd[wss_pkg::MODE_LSB +: 3];
        // load request only sticks if already enabled
        load_req_reg <= wd[wss_pkg::LOAD_BIT] & en_reg;
      end else if (load_req_reg && (rise_ev || fall_ev)) begin
        load_req_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dbr_reg <= 6'h00;
      dbf_reg <= 6'h00;
      dbr_act <= 6'h00;
      dbf_act <= 6'h00;
    end else if (clk_en) begin
      if (wr_dbr) begin
        dbr_reg <= wd[DB_HI:0];
      end
      if (wr_dbf) begin
        dbf_reg <= wd[DB_HI:0];
      end
      if (!en_reg) begin
        dbr_act <= dbr_reg;
        dbf_act <= dbf_reg;
      end else if (load_req_reg && (rise_ev || fall_ev)) begin
        dbr_act <= dbr_reg;
        dbf_act <= dbf_reg;
      end
    end
  end
  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pol_reg    <= 4'h0;
      src_en_reg <= 4'h0;
      str_reg    <= 4'h0;
      fix_reg    <= 4'h0;
      cs_reg     <= 1'b0;
    end else if (clk_en) begin
      if (wr_pol) begin
        pol_reg <= wd[3:0];
      end
      if (wr_src) begin
        src_en_reg <= wd[3:0];
      end
      if (wr_str) begin
        str_reg <= wd[3:0];
        fix_reg <= wd[wss_pkg::FIX_LSB +: 4];
      end
      if (wr_clk) begin
        cs_reg <= wd[wss_pkg::CS_BIT];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      str_sync <= 4'h0;
    end else if (clk_en) begin
      if (async_m || rise_ev) begin
        str_sync <= str_reg;
      end
    end
  end
  // ****************************************
  // shutdown status and override hold
  // ****************************************
  logic sd_set, sd_sw_clr, sd_auto_clr;
  assign sd_set      = src_act | (wr_sd & wd[wss_pkg::SD_BIT]);
  assign sd_sw_clr   = wr_sd & ~wd[wss_pkg::SD_BIT] & ~src_act;
  assign sd_auto_clr = ren_reg & ~src_act;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sd_reg   <= 1'b0;
      ren_reg  <= 1'b0;
      ovr_bd_reg <= wss_pkg::OVR_RST;
      ovr_ac_reg <= wss_pkg::OVR_RST;
    end else if (clk_en) begin
      if (wr_sd) begin
        ren_reg  <= wd[wss_pkg::REN_BIT];
        ovr_bd_reg <= wd[wss_pkg::OVR_BD_LSB +: 2];
        ovr_ac_reg <= wd[wss_pkg::OVR_AC_LSB +: 2];
      end
      // set beats any clear in the same cycle
      if (sd_set) begin
        sd_reg <= 1'b1;
      end else if (sd_sw_clr || sd_auto_clr) begin
        sd_reg <= 1'b0;
      end
    end
  end

  // override hold starts asserted so the outputs wake in shutdown
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_reg <= 1'b1;
      db_cnt   <= 6'h00;
    end else if (clk_en) begin
      if (sd_set || sd_reg) begin
        hold_reg <= 1'b1;
      end else if (rise_ev && en_reg) begin
        // a pin edge while disabled, e.g. just after reset, must not lift the start-up hold
        hold_reg <= 1'b0;
      end
      if (!hold_reg) begin
        db_cnt <= 6'h00;
      end else if (db_cnt != dbf_act) begin
        db_cnt <= db_cnt + 6'h01;
      end
    end
  end
  // ****************************************
  // output stage
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_o  <= 4'h0;
      out_oe <= 4'h0;
    end else if (clk_en) begin
      for (int i = 0; i < wss_pkg::NOUT; i++) begin
        if (!en_reg) begin
          out_o[i]  <= 1'b0;
          out_oe[i] <= 1'b0;
        end else if (hold_reg && (!steer || str_use[i])) begin
          // polarity does not touch the one and zero levels; the inactive level is pol_reg
          case (i[0] ? ovr_bd_reg : ovr_ac_reg)
            wss_pkg::OVR_ONE: begin
              out_o[i]  <= 1'b1;
              out_oe[i] <= 1'b1;
            end
            wss_pkg::OVR_ZERO: begin
              out_o[i]  <= 1'b0;
              out_oe[i] <= 1'b1;
            end
            wss_pkg::OVR_HIZ: begin
              out_o[i]  <= 1'b0;
              out_oe[i] <= 1'b0;
            end
            default: begin
              // last level kept until the dead band runs out
              if (db_cnt == dbf_act) begin
                out_o[i] <= pol_reg[i];
              end
              out_oe[i] <= 1'b1;
            end
          endcase
        end else if (steer && !str_use[i]) begin
          out_o[i]  <= fix_reg[i];
          out_oe[i] <= 1'b1;
        end else if (steer) begin
          out_o[i]  <= in_s ^ pol_reg[i];
          out_oe[i] <= 1'b1;
        end else begin
          // bridge and push-pull waveforms live elsewhere; park inactive
          out_o[i]  <= pol_reg[i];
          out_oe[i] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_keep_on <= 1'b0;
    end else if (clk_en) begin
      osc_keep_on <= en_reg & cs_reg;
    end
  end
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_FIXED_LEVEL: assert property (
    clk_en && en_reg && steer && !str_use[0] && !hold_reg |=> out_o[0] == $past(fix_reg[0]))
    else $error("unsteered output not at fixed level");
  AST_POLARITY: assert property (
    clk_en && en_reg && steer && str_use[0] && !hold_reg |=> out_o[0] == $past(in_s ^ pol_reg[0]))
    else $error("steered output wrong polarity");
  AST_SHUT_UNSTEERED: assert property (
    clk_en && en_reg && steer && hold_reg && !str_use[1] |=> out_o[1] == $past(fix_reg[1]) && out_oe[1])
    else $error("shutdown touched an unsteered output");
  AST_ASYNC_STEER: assert property (
    clk_en && wr_str && async_m && !wr_main |=> str_use == $past(wd[3:0]))
    else $error("async steering not immediate");
  AST_SYNC_STEER: assert property (
    clk_en && !async_m && !rise_ev |=> $stable(str_sync))
    else $error("sync steering changed off a rising edge");
  AST_SW_SHUTDOWN: assert property (
    clk_en && wr_sd && wd[wss_pkg::SD_BIT] |=> sd_reg && hold_reg)
    else $error("software shutdown not taken");
  AST_SRC_HOLDS: assert property (
    clk_en && src_act |=> sd_reg ##1 (hold_reg || !clk_en))
    else $error("active source did not keep shutdown");
  AST_HOLD_TILL_RISE: assert property (
    clk_en && hold_reg && !rise_ev |=> hold_reg)
    else $error("override released without rising edge");
  AST_LOAD_CLEARS: assert property (
    clk_en && load_req_reg && !wr_main && (rise_ev || fall_ev) |=> !load_req_reg && dbf_act == $past(dbf_reg))
    else $error("load request not serviced");
  AST_HIZ_OVR: assert property (
    clk_en && en_reg && hold_reg && !steer && ovr_ac_reg == wss_pkg::OVR_HIZ |=> !out_oe[0])
    else $error("high-z override drove the pin");
endmodule

// ### bench/wss_switch_stage.sv
// power switch stage model seen by the four generator outputs
`timescale 1ns/100ps
module wss_switch_stage (
  input  wire logic [3:0] out_o,
  input  wire logic [3:0] out_oe,
  output logic      [3:0] gate_level
);
  // gate drivers carry pull-downs, so a released output turns its switch off
  assign gate_level = out_oe & out_o;
endmodule

// ### bench/tb.sv
// self-checking bench for the steering and shutdown block
`timescale 1ns/100ps
module tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        wave_in = 1'b0;
  logic        ce = 1'b1;
  logic [3:0]  wstrb = 4'hf;
  logic [3:0]  src_n = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid, osc_keep_on;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [3:0]  out_o, out_oe, gate_level;
  int          bad_count = 0;
  int          comparisons = 0;
  int          seed = 57;
  // ************************************
  // reference state: start-up holds the overrides
  // ************************************
  int en = 0, mode = 0, steer = 0, pend = 0, pol = 0, fix = 0, sd = 0, hold = 1, ovr_ac = 1, ovr_bd = 1, wv = 0;

  wss_waveform_steering_shutdown wss_waveform_steering_shutdown_inst (
    .aclk(aclk), .aresetn(aresetn), .clk_en(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .wave_in(wave_in), .comparator_one_sync_out(src_n[2]), .comparator_two_sync_out(src_n[3]),
    .timer_postscaled_out(src_n[1]), .shutdown_input_pin(src_n[0]),
    .out_o(out_o), .out_oe(out_oe), .osc_keep_on(osc_keep_on));

  wss_switch_stage wss_switch_stage_inst (.out_o(out_o), .out_oe(out_oe), .gate_level(gate_level));

  initial begin
    forever #50 aclk = ~aclk;
  end

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic fail(input string m);
    bad_count++;
    $display("mismatch at %0t: %s", $time, m);
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
    comparisons++;
    if (g !== e) fail(m);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 50) begin
      fail("write timeout");
      end_of_test();
    end
    cmp(bresp, wss_pkg::RESP_OKAY, "bresp");
    // a write with its low byte lane off changes nothing
    case (wstrb[0] ? a : 8'hff)
      wss_pkg::OFF_MAIN: begin
        en = d[7];
        mode = d[2:0];
        if (mode == 0) steer = pend;
      end
      wss_pkg::OFF_POL: pol = d[3:0];
      wss_pkg::OFF_SD: begin
        sd = d[7];
        ovr_bd = d[5:4];
        ovr_ac = d[3:2];
        if (d[7]) hold = 1;
      end
      wss_pkg::OFF_STR: begin
        pend = d[3:0];
        fix = d[7:4];
        if (mode == 0) steer = pend;
      end
      default: ;
    endcase
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = wss_pkg::RESP_OKAY);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 50) begin
      fail("read timeout");
      end_of_test();
    end
    cmp(rdata, e, "rdata");
    cmp(rresp, er, "rresp");
  endtask

  // pin to logic is two sync stages plus the output register
  task automatic wave(input int w);
    @(posedge aclk);
    wave_in <= w[0];
    if (w != 0 && wv == 0) begin
      if (mode == 1) steer = pend;
      if (sd == 0 && en != 0) hold = 0;
    end
    wv = w;
    cyc(5);
  endtask

  task automatic chk;
    logic [3:0] eo, eoe;
    for (int i = 0; i < 4; i++) begin
      int lv;
      logic ov;
      lv = i[0] ? ovr_bd : ovr_ac;
      // bridge modes override every output, steering modes only the steered ones
      ov = hold != 0 && (mode > 1 || steer[i]);
      eoe[i] = en != 0 && !(ov && lv == 1);
      eo[i] = (en == 0) ? 1'b0 : ov ? (lv == 0 ? pol[i] : lv[0]) :
              (mode > 1) ? pol[i] : steer[i] ? wv[0] ^ pol[i] : fix[i];
    end
    comparisons++;
    if (out_oe !== eoe || (out_o & eoe) !== (eo & eoe) || gate_level !== (eo & eoe)) fail("outputs");
  endtask

  initial begin
    repeat (50000) @(posedge aclk);
    fail("run timeout");
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    chk();
    rd(wss_pkg::OFF_MAIN, 32'h0);
    rd(wss_pkg::OFF_SD, 32'h14);
    rd(8'h40, 32'h0, wss_pkg::RESP_SLV);
    for (int m = 0; m < 6; m++) begin
      wr(wss_pkg::OFF_MAIN, m);
      rd(wss_pkg::OFF_MAIN, m);
    end
    wr(wss_pkg::OFF_POL, 32'h3);
    wr(wss_pkg::OFF_STR, 32'ha5);
    wr(wss_pkg::OFF_SD, 32'hb8);
    wr(wss_pkg::OFF_MAIN, 32'h80);
    cyc(3);
    chk();
    wave(1);
    chk();
    rd(wss_pkg::OFF_POL, 32'h23);
    wr(wss_pkg::OFF_MAIN, 32'hc0);
    wave(0);
    wave(1);
    rd(wss_pkg::OFF_MAIN, 32'h80);
    wr(wss_pkg::OFF_SD, 32'h38);
    chk();
    wave(0);
    wave(1);
    chk();
    repeat (12) begin
      wr(wss_pkg::OFF_POL, $random(seed) & 15);
      wr(wss_pkg::OFF_STR, $random(seed) & 255);
      cyc(2);
      chk();
      wave($random(seed) & 1);
      chk();
    end
    wr(wss_pkg::OFF_MAIN, 32'h81);
    wave(0);
    wr(wss_pkg::OFF_STR, 32'h0f);
    cyc(2);
    chk();
    wave(1);
    chk();
    // clock enable low: a pin change must not reach the outputs
    ce <= 1'b0;
    wave_in <= 1'b0;
    cyc(4);
    chk();
    wave_in <= 1'b1;
    cyc(1);
    ce <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(wss_pkg::OFF_SRC, 1 << i);
      src_n[i] <= 1'b0;
      cyc(6);
      sd = 1;
      hold = 1;
      chk();
      wr(wss_pkg::OFF_SD, 32'h38);
      sd = 1;
      rd(wss_pkg::OFF_SD, 32'hb8);
      src_n[i] <= 1'b1;
      cyc(6);
      wr(wss_pkg::OFF_SD, 32'h38);
      rd(wss_pkg::OFF_SD, 32'h38);
      wave(0);
      wave(1);
      chk();
    end
    wr(wss_pkg::OFF_SRC, 32'h0);
    src_n <= 4'h0;
    cyc(6);
    chk();
    rd(wss_pkg::OFF_SD, 32'h38);
    src_n <= 4'hf;
    wr(wss_pkg::OFF_SRC, 32'h1);
    wr(wss_pkg::OFF_SD, 32'h78);
    src_n[0] <= 1'b0;
    cyc(6);
    rd(wss_pkg::OFF_SD, 32'hf8);
    src_n[0] <= 1'b1;
    cyc(6);
    rd(wss_pkg::OFF_SD, 32'h78);
    hold = 1;
    chk();
    wave(0);
    wave(1);
    chk();
    wr(wss_pkg::OFF_SD, 32'hf8);
    rd(wss_pkg::OFF_SD, 32'h78);
    sd = 0;
    wave(0);
    wave(1);
    chk();
    wr(wss_pkg::OFF_DBF, 32'h05);
    wr(wss_pkg::OFF_MAIN, 32'hc1);
    wave(0);
    wave(1);
    rd(wss_pkg::OFF_MAIN, 32'h81);
    rd(wss_pkg::OFF_DBF, 32'h05);
    wr(wss_pkg::OFF_DBR, 32'hea);
    rd(wss_pkg::OFF_DBR, 32'h2a);
    // B/D inactive after the dead band, A/C released
    wr(wss_pkg::OFF_SD, 32'h84);
    cyc(2);
    cmp(out_o & 4'ha, ~pol & 32'ha, "dead band keeps last level");
    cmp(out_oe, 32'ha, "high-z override");
    cyc(6);
    chk();
    wr(wss_pkg::OFF_MAIN, 32'h84);
    cyc(2);
    chk();
    wr(wss_pkg::OFF_CLK, 32'h1);
    cyc(2);
    cmp(osc_keep_on, 32'h1, "oscillator");
    wr(wss_pkg::OFF_MAIN, 32'h01);
    cyc(2);
    cmp(osc_keep_on, 32'h0, "oscillator");
    chk();
    // load request in the enabling write is dropped by this design
    wr(wss_pkg::OFF_MAIN, 32'hc0);
    rd(wss_pkg::OFF_MAIN, 32'h80);
    wstrb <= 4'h0;
    wr(wss_pkg::OFF_MAIN, 32'h00);
    rd(wss_pkg::OFF_MAIN, 32'h80);
    wstrb <= 4'hf;
    // reset in mid-run with the pin high: its first synced edge must not lift the hold
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    en = 0;
    hold = 1;
    ovr_ac = 1;
    ovr_bd = 1;
    rd(wss_pkg::OFF_SD, 32'h14);
    rd(wss_pkg::OFF_MAIN, 32'h0);
    wr(wss_pkg::OFF_MAIN, 32'h84);
    cyc(2);
    chk();
    end_of_test();
  end
endmodule
